// File: rtl/vpi_pkg.sv
/*
 * Constants for the vectored priority interrupt controller: SFR offsets,
 * source indices, vector addresses, group mapping and trigger modes.
 * Assumes an 8-bit SFR write/read port driven by the processor core.
 */
//==========================================================================
// Behaviour
// R1 - sixteen sources, five groups, four levels
// R2 - preempt only strictly higher level
// R3 - base sources jump to fixed vectors
// R4 - extended sources jump to fixed vectors
// R5 - commutation, core, hall edge sensitivities
// R6 - ext zero pin choice, level or fall
// R7 - ext one on port2 bit5, level/fall
// R8 - port1 pins irq, status records pin
// R9 - motor events routed into vectored scheme
// R10 - enable, flag, priority conventionally handled
// R11 - fault from short, hall slow, error
// R12 - adc ready after stored result
// R13 - enable per source (SPI enable follows IEN0 bit6 with I2C), edge flags auto-clear
// R14 - equal level resolved by vector order
package vpi_pkg;
   localparam int NSRC = 16;
   localparam int NGRP = 5;
   // sfr offsets
   localparam logic [7:0] ADDR_IOSEL = 8'hF9;
   localparam logic [7:0] ADDR_P1CFG = 8'hFA;
   localparam logic [7:0] ADDR_P1STA = 8'hFB;
   localparam logic [7:0] ADDR_IEN0 = 8'hA8;
   localparam logic [7:0] ADDR_IEN1 = 8'hB8;
   localparam logic [7:0] ADDR_PRIO = 8'hA9;
   localparam logic [7:0] ADDR_TRIG = 8'h88;
   localparam logic [7:0] IOSEL_RST = 8'h00;
   // io_function_select bit picking port2 bit6 for ext zero
   localparam int IOSEL_EX0_BIT = 4;
   // source indices (polling order = ascending vector)
   localparam int S_EX0 = 0;
   localparam int S_T0 = 1;
   localparam int S_EX1 = 2;
   localparam int S_T1 = 3;
   localparam int S_SER = 4;
   localparam int S_T2 = 5;
   localparam int S_I2C = 6;
   localparam int S_SPI = 7;
   localparam int S_COM0 = 8;
   localparam int S_COM1 = 9;
   localparam int S_COM2 = 10;
   localparam int S_FLT = 11;
   localparam int S_ADC = 12;
   localparam int S_HALL = 13;
   localparam int S_CORE = 14;
   localparam int S_P1 = 15;
   localparam logic [15:0] VECTOR [NSRC] = '{
      16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
      16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h008B,
      16'h0093, 16'h009B, 16'h00A3, 16'h00AB};
   // priority group of each source
   localparam logic [2:0] GROUP [NSRC] = '{
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h0, 3'h1,
      3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h1, 3'h0, 3'h2};
   typedef enum logic [1:0] {
      EDGE_RISE, EDGE_FALL, EDGE_BOTH
   } vpi_edge_type;
   localparam logic [1:0] EDGE_SEL_RISE = 2'h0;
   localparam logic [1:0] EDGE_SEL_FALL = 2'h1;
endpackage : vpi_pkg

// File: rtl/vpi_edge_det.sv
/*
 * Edge detector with selectable sensitivity.
 * Assumes sig is already synchronous to clock.
 */
`timescale 1ns/1ns
module vpi_edge_det
   import vpi_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic sig,
   input wire logic [1:0] mode,
   output logic pulse
);
   logic prev_ff;
   logic nxt_prev;
   logic rise;
   logic fall;
   always_comb begin
      nxt_prev = sig;
      rise = sig & ~prev_ff;
      fall = ~sig & prev_ff;
      // R5 edge selection
      if (mode == EDGE_SEL_RISE) begin
         pulse = rise;
      end else if (mode == EDGE_SEL_FALL) begin
         pulse = fall;
      end else begin
         pulse = rise | fall;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         // start at the input's level so release gives no false edge
         prev_ff <= sig;
      end else begin
         prev_ff <= nxt_prev;
      end
   end
endmodule : vpi_edge_det

// File: rtl/vpi_controller.sv
/*
 * Vectored priority interrupt controller: source capture, pending flags,
 * level arbitration with nesting, vector hand-off and SFR port.
 * Assumes the core pulses intAck when it branches and intReti on return;
 * peripheral event inputs are one-cycle pulses on clock, pins asynchronous.
 */
`timescale 1ns/1ns
module vpi_controller
   import vpi_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   input wire logic port2Bit4,
   input wire logic port2Bit5,
   input wire logic port2Bit6,
   input wire logic [6:0] port1Pins,
   input wire logic timerZeroOvf,
   input wire logic timerOneOvf,
   input wire logic timerTwoIrq,
   input wire logic asyncSerialIrq,
   input wire logic twoWireBusIrq,
   input wire logic serialPeriphIrq,
   input wire logic comZero,
   input wire logic comOne,
   input wire logic comTwo,
   input wire logic [2:0] phaseShort,
   input wire logic hallSlow,
   input wire logic [2:0] hallInputs,
   input wire logic adcStored,
   input wire logic lowVoltWarn,
   input wire logic hallEdge,
   input wire logic motorCore,
   input wire logic intAck,
   input wire logic intReti,
   output logic intReq,
   output logic [15:0] intVector
);
   //=======================================================================
   // pin synchronisers
   logic [9:0] syncA_ff;
   logic [9:0] syncB_ff;
   logic [9:0] pinRaw;
   logic ex0Pin;
   logic ex1Pin;
   logic [6:0] p1Pin;
   assign pinRaw = {port1Pins, port2Bit6, port2Bit5, port2Bit4};
   always_ff @(posedge clock) begin
      if (rst) begin
         syncA_ff <= '1;
         syncB_ff <= '1;
      end else begin
         syncA_ff <= pinRaw;
         syncB_ff <= syncA_ff;
      end
   end
   //=======================================================================
   // registers
   logic [7:0] ioSel_ff, nxt_ioSel;
   logic [7:0] p1Cfg_ff, nxt_p1Cfg;
   logic [6:0] p1Sta_ff, nxt_p1Sta;
   logic [15:0] enable_ff, nxt_enable;
   logic globalEn_ff, nxt_globalEn;
   logic [9:0] prio_ff, nxt_prio;
   logic [3:0] trig_ff, nxt_trig;
   logic [15:0] pend_ff, nxt_pend;
   logic [3:0] active_ff, nxt_active;
   logic [15:0] reqVec_ff, nxt_reqVec;
   logic reqOut_ff, nxt_reqOut;
   logic [3:0] reqSrc_ff, nxt_reqSrc;
   logic [7:0] rdata_ff, nxt_rdata;
   // R6 ext zero pin choice
   assign ex0Pin = ioSel_ff[IOSEL_EX0_BIT] ? syncB_ff[2] : syncB_ff[0];
   // R7 ext one from port2 bit5
   assign ex1Pin = syncB_ff[1];
   assign p1Pin = syncB_ff[9:3];
   //=======================================================================
   // edge capture
   logic ex0Fall, ex1Fall, com0Ev, com1Ev, com2Ev, hallEv, coreEv;
   logic [6:0] p1Ev;
   logic [1:0] p1Mode;
   assign p1Mode = p1Cfg_ff[1:0];
   vpi_edge_det u_ex0 (.clock(clock), .rst(rst), .sig(ex0Pin),
      .mode(EDGE_SEL_FALL), .pulse(ex0Fall));
   vpi_edge_det u_ex1 (.clock(clock), .rst(rst), .sig(ex1Pin),
      .mode(EDGE_SEL_FALL), .pulse(ex1Fall));
   // R5 commutation zero both edges, hall as set by p1Cfg bits 3:2, others rising
   vpi_edge_det u_c0 (.clock(clock), .rst(rst), .sig(comZero),
      .mode(EDGE_BOTH), .pulse(com0Ev));
   vpi_edge_det u_c1 (.clock(clock), .rst(rst), .sig(comOne),
      .mode(EDGE_SEL_RISE), .pulse(com1Ev));
   vpi_edge_det u_c2 (.clock(clock), .rst(rst), .sig(comTwo),
      .mode(EDGE_SEL_RISE), .pulse(com2Ev));
   vpi_edge_det u_core (.clock(clock), .rst(rst), .sig(motorCore),
      .mode(EDGE_SEL_RISE), .pulse(coreEv));
   vpi_edge_det u_hall (.clock(clock), .rst(rst), .sig(hallEdge),
      .mode(p1Cfg_ff[3:2]), .pulse(hallEv));
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_p1
         // R8 any port1 pin
         vpi_edge_det u_p1 (.clock(clock), .rst(rst), .sig(p1Pin[gi]),
            .mode(p1Mode), .pulse(p1Ev[gi]));
      end
   endgenerate
   //=======================================================================
   // event set vector
   logic [15:0] setEv;
   logic [15:0] levelReq;
   logic faultEv;
   logic hallBad;
   // R11 fault causes; hall all zeros or ones
   assign hallBad = (hallInputs == 3'b000) | (hallInputs == 3'b111);
   assign faultEv = (|phaseShort) | hallSlow | hallBad | lowVoltWarn;
   always_comb begin
      setEv = '0;
      levelReq = '0;
      // R6 R7 level or falling edge by trigger bits
      setEv[S_EX0] = trig_ff[0] ? ex0Fall : 1'b0;
      levelReq[S_EX0] = ~trig_ff[0] & ~ex0Pin;
      setEv[S_EX1] = trig_ff[2] ? ex1Fall : 1'b0;
      levelReq[S_EX1] = ~trig_ff[2] & ~ex1Pin;
      setEv[S_T0] = timerZeroOvf;
      setEv[S_T1] = timerOneOvf;
      setEv[S_T2] = timerTwoIrq;
      setEv[S_SER] = asyncSerialIrq;
      setEv[S_I2C] = twoWireBusIrq;
      setEv[S_SPI] = serialPeriphIrq;
      setEv[S_COM0] = com0Ev;
      setEv[S_COM1] = com1Ev;
      setEv[S_COM2] = com2Ev;
      // R9 motor events into the vectored scheme
      setEv[S_FLT] = faultEv;
      // R12 adc ready after result stored
      setEv[S_ADC] = adcStored;
      setEv[S_HALL] = hallEv;
      setEv[S_CORE] = coreEv;
      setEv[S_P1] = |p1Ev;
   end
   //=======================================================================
   // arbitration
   logic [15:0] req;
   logic [1:0] srcLvl [NSRC];
   logic found;
   logic [3:0] winSrc;
   logic [1:0] winLvl;
   logic [2:0] curLvl;
   always_comb begin
      // R1 each group carries a two-bit level
      for (int i = 0; i < NSRC; i++) begin
         srcLvl[i] = prio_ff[2*GROUP[i] +: 2];
      end
      // R13 enable gates each pending flag
      req = (pend_ff | levelReq) & enable_ff & {NSRC{globalEn_ff}};
      found = 1'b0;
      winSrc = '0;
      winLvl = '0;
      // R14 ascending vector order within a level
      for (int l = 3; l >= 0; l--) begin
         for (int i = 0; i < NSRC; i++) begin
            if (!found && req[i] && srcLvl[i] == l[1:0]) begin
               found = 1'b1;
               winSrc = i[3:0];
               winLvl = l[1:0];
            end
         end
      end
      curLvl = 3'h0;
      for (int l = 0; l < 4; l++) begin
         if (active_ff[l]) begin
            curLvl = 3'(l + 1);
         end
      end
   end
   // level of the source whose vector is on offer
   logic [1:0] reqLvlIdx;
   assign reqLvlIdx = srcLvl[reqSrc_ff];
   //=======================================================================
   // next state
   always_comb begin
      nxt_ioSel = ioSel_ff;
      nxt_p1Cfg = p1Cfg_ff;
      nxt_enable = enable_ff;
      nxt_globalEn = globalEn_ff;
      nxt_prio = prio_ff;
      nxt_trig = trig_ff;
      nxt_pend = pend_ff;
      nxt_p1Sta = p1Sta_ff;
      nxt_active = active_ff;
      nxt_rdata = rdata_ff;
      if (sfrWr) begin
         unique case (sfrAddr)
            ADDR_IOSEL: nxt_ioSel = sfrWdata;
            ADDR_P1CFG: nxt_p1Cfg = sfrWdata;
            ADDR_P1STA: nxt_p1Sta = p1Sta_ff & sfrWdata[6:0];
            ADDR_IEN0: begin
               nxt_enable[7:0] = {1'b0, sfrWdata[6:0]};
               nxt_globalEn = sfrWdata[7];
            end
            ADDR_IEN1: nxt_enable[15:8] = sfrWdata;
            // group four level lives in the trigger register
            ADDR_PRIO: nxt_prio[7:0] = sfrWdata;
            ADDR_TRIG: nxt_trig = sfrWdata[3:0];
            default: begin
               nxt_pend = pend_ff;
            end
         endcase
         if (sfrAddr == ADDR_IEN0) begin
            nxt_enable[7] = sfrWdata[6];
         end
         if (sfrAddr == ADDR_TRIG) begin
            nxt_prio[9:8] = sfrWdata[5:4];
         end
      end
      // R13 edge flags clear on acceptance
      if (intAck && reqOut_ff) begin
         nxt_pend[reqSrc_ff] = 1'b0;
         nxt_active[reqLvlIdx] = 1'b1;
      end
      if (intReti) begin
         for (int l = 0; l < 4; l++) begin
            if (active_ff[l] && 3'(l + 1) == curLvl) begin
               nxt_active[l] = 1'b0;
            end
         end
      end
      // set after clear so a same-cycle event is kept
      nxt_pend = nxt_pend | setEv;
      // R8 pin status records triggering pin
      nxt_p1Sta = nxt_p1Sta | p1Ev;
      nxt_rdata = 8'h00;
      if (sfrRd) begin
         unique case (sfrAddr)
            ADDR_IOSEL: nxt_rdata = ioSel_ff;
            ADDR_P1CFG: nxt_rdata = p1Cfg_ff;
            ADDR_P1STA: nxt_rdata = {1'b0, p1Sta_ff};
            ADDR_IEN0: nxt_rdata = {globalEn_ff, enable_ff[6:0]};
            ADDR_IEN1: nxt_rdata = enable_ff[15:8];
            ADDR_PRIO: nxt_rdata = prio_ff[7:0];
            ADDR_TRIG: nxt_rdata = {2'b00, prio_ff[9:8], trig_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
      // R2 preempt only strictly higher level
      nxt_reqOut = found && ({1'b0, winLvl} >= curLvl) &&
         !(intAck && reqOut_ff);
      nxt_reqSrc = winSrc;
      // R3 R4 fixed vector per source
      nxt_reqVec = VECTOR[winSrc];
   end
   //=======================================================================
   // registers
   always_ff @(posedge clock) begin
      if (rst) begin
         ioSel_ff <= IOSEL_RST;
         p1Cfg_ff <= 8'h00;
         p1Sta_ff <= 7'h00;
         enable_ff <= 16'h0000;
         globalEn_ff <= 1'b0;
         prio_ff <= 10'h000;
         trig_ff <= 4'h0;
         pend_ff <= 16'h0000;
         active_ff <= 4'h0;
         reqVec_ff <= 16'h0000;
         reqOut_ff <= 1'b0;
         reqSrc_ff <= 4'h0;
         rdata_ff <= 8'h00;
      end else begin
         ioSel_ff <= nxt_ioSel;
         p1Cfg_ff <= nxt_p1Cfg;
         p1Sta_ff <= nxt_p1Sta;
         enable_ff <= nxt_enable;
         globalEn_ff <= nxt_globalEn;
         prio_ff <= nxt_prio;
         trig_ff <= nxt_trig;
         pend_ff <= nxt_pend;
         active_ff <= nxt_active;
         reqVec_ff <= nxt_reqVec;
         reqOut_ff <= nxt_reqOut;
         reqSrc_ff <= nxt_reqSrc;
         rdata_ff <= nxt_rdata;
      end
   end
   // R10 conventional request/vector hand-off
   assign intReq = reqOut_ff;
   assign intVector = reqVec_ff;
   assign sfrRdata = rdata_ff;
endmodule : vpi_controller

// File: sim/vpi_controller_checker.sv
/* Port checker for the interrupt controller: acknowledge, vector form,
   register read-back and global enable. Bound to every controller. */
`timescale 1ns/1ns
module vpi_controller_checker
   import vpi_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   input wire logic [7:0] sfrRdata,
   input wire logic intAck,
   input wire logic intReq,
   input wire logic [15:0] intVector
);
   //=======================================================
   // helper: shadow of the global enable bit
   logic gEn_ff;
   logic nxt_gEn;
   always_comb begin
      nxt_gEn = gEn_ff;
      if (sfrWr && sfrAddr == ADDR_IEN0) begin
         nxt_gEn = sfrWdata[7];
      end
   end
   always_ff @(posedge clock) begin
      gEn_ff <= rst ? 1'b0 : nxt_gEn;
   end
   //=======================================================
   // properties
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_wrrd(a);
      sfrWr && sfrAddr == a ##1 sfrRd && !sfrWr && sfrAddr == a;
   endsequence
   property p_ack_drop;
      intAck && intReq |=> !intReq;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("req after ack");
   property p_vec_form;
      intReq |-> intVector[15:8] == 8'h00 && intVector[2:0] == 3'h3;
   endproperty
   a_vec_form: assert property (p_vec_form) else $error("bad vector");
   property p_rd_idle;
      !sfrRd |=> sfrRdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("data w/o read");
   property p_rd_unmapped;
      sfrRd && sfrAddr == 8'h00 |=> sfrRdata == 8'h00;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped");
   property p_gen_off;
      (!gEn_ff) [*3] |-> !intReq;
   endproperty
   a_gen_off: assert property (p_gen_off) else $error("req disabled");
   property p_rb_iosel;
      s_wrrd(ADDR_IOSEL) |=> sfrRdata == $past(sfrWdata, 2);
   endproperty
   a_rb_iosel: assert property (p_rb_iosel) else $error("iosel rb");
   property p_rb_ien0;
      s_wrrd(ADDR_IEN0) |=> sfrRdata == $past(sfrWdata, 2);
   endproperty
   a_rb_ien0: assert property (p_rb_ien0) else $error("ien0 rb");
   property p_rb_ien1;
      s_wrrd(ADDR_IEN1) |=> sfrRdata == $past(sfrWdata, 2);
   endproperty
   a_rb_ien1: assert property (p_rb_ien1) else $error("ien1 rb");
   property p_rb_prio;
      s_wrrd(ADDR_PRIO) |=> sfrRdata == $past(sfrWdata, 2);
   endproperty
   a_rb_prio: assert property (p_rb_prio) else $error("prio rb");
   c_ack: cover property (intAck && intReq);
   c_fault: cover property (intAck && intVector == 16'h008B);
   c_pin: cover property (intAck && intVector == 16'h00AB);
endmodule : vpi_controller_checker

bind vpi_controller vpi_controller_checker u_chk (.clock, .rst, .sfrWr,
   .sfrRd, .sfrAddr, .sfrWdata, .sfrRdata, .intAck, .intReq, .intVector);

// File: sim/vpi_core_model.sv
/* Processor core model: takes a standing request, reports the vector it
   took, returns on command. Assumes intReq drops after one acknowledge. */
`timescale 1ns/1ns
module vpi_core_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic intReq,
   input wire logic [15:0] intVector,
   input wire logic slowAck,
   input wire logic doReti,
   output logic intAck,
   output logic intReti,
   output logic ackStb,
   output logic [15:0] ackVec
);
   logic [1:0] waitCnt;
   //=======================================================
   // a slow core lets the request stand three more cycles
   always_ff @(posedge clock) begin
      if (rst) begin
         intAck <= 1'b0;
         intReti <= 1'b0;
         ackStb <= 1'b0;
         ackVec <= 16'h0000;
         waitCnt <= 2'h0;
      end else begin
         intReti <= doReti;
         intAck <= 1'b0;
         ackStb <= 1'b0;
         if (intReq && !intAck) begin
            if (slowAck && waitCnt != 2'h3) begin
               waitCnt <= waitCnt + 2'h1;
            end else begin
               intAck <= 1'b1;
               ackStb <= 1'b1;
               ackVec <= intVector;
               waitCnt <= 2'h0;
            end
         end
      end
   end
endmodule : vpi_core_model

// File: sim/test_vectored_priority_interrupts.sv
/* Testbench: every source once, equal-level order, nesting, registers.
   Assumes the core model and the bound checker. */
`timescale 1ns/1ns
module test_vectored_priority_interrupts import vpi_pkg::*;;
   logic clock, rst, sfrWr, sfrRd, doReti, slowAck, intAck, intReti, intReq;
   logic [7:0] sfrAddr, sfrWdata, sfrRdata;
   logic port2Bit4, port2Bit5, port2Bit6, timerZeroOvf, timerOneOvf;
   logic timerTwoIrq, asyncSerialIrq, twoWireBusIrq, serialPeriphIrq;
   logic comZero, comOne, comTwo, hallSlow, adcStored, lowVoltWarn;
   logic hallEdge, motorCore, ackStb, rdPend;
   logic [6:0] port1Pins;
   logic [2:0] phaseShort, hallInputs;
   logic [15:0] intVector, ackVec;
   logic [15:0] expQ[$];
   logic [7:0] rdQ[$];
   int error_cnt = 0, check_count = 0, ackCnt = 0, pin, fbit;
   localparam logic [15:0] EXPV [16] = '{16'h0003, 16'h000B, 16'h0013,
      16'h001B, 16'h0023, 16'h002B, 16'h0043, 16'h004B, 16'h0053, 16'h005B,
      16'h0063, 16'h008B, 16'h0093, 16'h009B, 16'h00A3, 16'h00AB};
   initial begin
      {rst, port2Bit4, port2Bit5, port2Bit6, port1Pins} = '1;
      {sfrWr, sfrRd, doReti, slowAck, timerZeroOvf, timerOneOvf} = '0;
      {timerTwoIrq, asyncSerialIrq, twoWireBusIrq, serialPeriphIrq} = '0;
      {comZero, comOne, comTwo, hallSlow, adcStored, lowVoltWarn} = '0;
      {hallEdge, motorCore, rdPend, sfrAddr, sfrWdata, phaseShort} = '0;
      // all zeros or all ones would raise the fault source
      hallInputs = 3'h1;
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   vpi_controller dut (.clock, .rst, .sfrWr, .sfrRd, .sfrAddr, .sfrWdata,
      .sfrRdata, .port2Bit4, .port2Bit5, .port2Bit6, .port1Pins,
      .timerZeroOvf, .timerOneOvf, .timerTwoIrq, .asyncSerialIrq,
      .twoWireBusIrq, .serialPeriphIrq, .comZero, .comOne, .comTwo,
      .phaseShort, .hallSlow, .hallInputs, .adcStored, .lowVoltWarn,
      .hallEdge, .motorCore, .intAck, .intReti, .intReq, .intVector);
   vpi_core_model core (.clock, .rst, .intReq, .intVector, .slowAck,
      .doReti, .intAck, .intReti, .ackStb, .ackVec);
   //=======================================================
   // shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // caller is just past an edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfrRd <= 1'b1;
      sfrAddr <= a;
      rdQ.push_back(e);
      @(posedge clock);
      sfrRd <= 1'b0;
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit rb);
      @(posedge clock);
      sfrWr <= 1'b1;
      sfrAddr <= a;
      sfrWdata <= d;
      @(posedge clock);
      sfrWr <= 1'b0;
      if (rb) rd(a, d);
   endtask : wr
   task automatic wait_ack(input int n);
      for (int i = 0; i < 60 && ackCnt == n; i++) @(posedge clock);
      if (ackCnt == n) begin
         chk(16'(ackCnt), 16'(n + 1));
         complete_run();
      end
   endtask : wait_ack
   task automatic drive(input int s, input logic v);
      case (s)
         0: port2Bit6 <= !v;
         1: timerZeroOvf <= v;
         2: port2Bit5 <= !v;
         3: timerOneOvf <= v;
         4: asyncSerialIrq <= v;
         5: timerTwoIrq <= v;
         6: twoWireBusIrq <= v;
         7: serialPeriphIrq <= v;
         8: if (v) comZero <= !comZero;
         9: comOne <= v;
         10: comTwo <= v;
         11: phaseShort[fbit] <= v;
         12: adcStored <= v;
         13: hallEdge <= v;
         14: motorCore <= v;
         default: port1Pins[pin] <= !v;
      endcase
   endtask : drive
   task automatic retire();
      repeat (4) @(posedge clock);
      doReti <= 1'b1;
      @(posedge clock);
      doReti <= 1'b0;
   endtask : retire
   task automatic fire(input int s, input bit ret);
      int n;
      n = ackCnt;
      expQ.push_back(EXPV[s]);
      @(posedge clock);
      drive(s, 1'b1);
      // the level source on port2 stays low until taken
      if (s != 0) begin
         @(posedge clock);
         drive(s, 1'b0);
      end
      wait_ack(n);
      if (s == 0) drive(0, 1'b0);
      if (ret) retire();
   endtask : fire
   // b arrives while a is in service: it waits for the return unless
   // its level is higher, in which case it nests at once
   task automatic held(input int a, input int b, input bit pre);
      int n;
      fire(a, 1'b0);
      if (pre) begin
         fire(b, 1'b1);
      end else begin
         n = ackCnt;
         expQ.push_back(EXPV[b]);
         @(posedge clock);
         drive(b, 1'b1);
         @(posedge clock);
         drive(b, 1'b0);
         repeat (8) @(posedge clock);
         chk(16'(ackCnt), 16'(n));
         retire();
         wait_ack(n);
      end
      retire();
   endtask : held
   // a and b pend together at one level; a must be taken first
   task automatic pair_order(input int a, input int b);
      int n;
      n = ackCnt;
      expQ.push_back(EXPV[a]);
      expQ.push_back(EXPV[b]);
      @(posedge clock);
      drive(a, 1'b1);
      drive(b, 1'b1);
      @(posedge clock);
      drive(a, 1'b0);
      drive(b, 1'b0);
      wait_ack(n);
      retire();
      wait_ack(n + 1);
      retire();
   endtask : pair_order
   //=======================================================
   // result watcher
   always @(posedge clock) begin
      if (ackStb) begin
         ackCnt <= ackCnt + 1;
         chk(ackVec, expQ.size() > 0 ? expQ.pop_front() : 16'hFFFF);
      end
      if (rdPend) chk({8'h00, sfrRdata}, {8'h00, rdQ.pop_front()});
      rdPend <= sfrRd;
   end
   //=======================================================
   // main sequence
   initial begin
      void'($urandom(32'hdca0));
      pin = $urandom_range(6);
      fbit = $urandom_range(2);
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      wr(ADDR_IEN0, 8'h7F, 1'b1);
      wr(ADDR_IOSEL, 8'($urandom), 1'b1);
      wr(ADDR_PRIO, 8'($urandom), 1'b1);
      wr(ADDR_IEN1, 8'($urandom), 1'b1);
      @(posedge clock);
      rd(8'h00, 8'h00);
      wr(ADDR_IOSEL, 8'h10, 1'b0);
      wr(ADDR_PRIO, 8'h00, 1'b0);
      wr(ADDR_IEN1, 8'hFF, 1'b0);
      wr(ADDR_TRIG, 8'h04, 1'b0);
      wr(ADDR_IEN0, 8'hFF, 1'b0);
      for (int s = 0; s < 16; s++) begin
         slowAck <= s[0];
         fire(s, 1'b1);
      end
      @(posedge clock);
      rd(ADDR_P1STA, 8'(1 << pin));
      wr(ADDR_P1STA, 8'h00, 1'b1);
      pair_order(1, 3);
      held(1, 3, 1'b0);
      // timer one's group raised above timer zero's
      wr(ADDR_PRIO, 8'h80, 1'b1);
      held(1, 3, 1'b1);
      repeat (8) @(posedge clock);
      chk(16'(ackCnt), 16'(22));
      chk(16'(expQ.size()), 16'h0000);
      complete_run();
   end
endmodule : test_vectored_priority_interrupts
